// File: rtl/psr_pkg.sv
// Package with register map, field layout and reset values of the peripheral soft reset block.
package psr_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned psr_addr_w = 12;
    localparam logic [11:0] psr_off_periph = 12'h0044;
    localparam logic [11:0] psr_off_port = 12'h0048;

    // ------------------------------------------------------------
    // Field positions of the first reset register
    // ------------------------------------------------------------
    localparam int unsigned psr_bit_comparator_zero = 24;
    localparam int unsigned psr_bit_gp_counter_two = 18;
    localparam int unsigned psr_bit_gp_counter_one = 17;
    localparam int unsigned psr_bit_gp_counter_zero = 16;
    localparam int unsigned psr_bit_two_wire_zero = 12;
    localparam int unsigned psr_bit_sync_serial_zero = 4;
    localparam int unsigned psr_bit_async_serial_one = 1;
    localparam int unsigned psr_bit_async_serial_zero = 0;

    // ------------------------------------------------------------
    // Implemented bits and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] psr_periph_impl = 32'h0107_1013;
    localparam logic [31:0] psr_port_impl = 32'h0000_001f;
    localparam int unsigned psr_port_count = 5;
    localparam logic [31:0] psr_reset_value = 32'h0000_0000;

    // ------------------------------------------------------------
    // Register selector
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        psr_sel_none = 3'b001,
        psr_sel_periph = 3'b010,
        psr_sel_port = 3'b100
    } psr_sel_type;

    function automatic psr_sel_type psr_decode(input logic [11:0] addr);
        psr_sel_type sel;
        sel = psr_sel_none;
        if (addr == psr_off_periph)
        begin
            sel = psr_sel_periph;
        end
        else if (addr == psr_off_port)
        begin
            sel = psr_sel_port;
        end
        return sel;
    endfunction : psr_decode

endpackage : psr_pkg

// File: rtl/psr_masked_reg.sv
// Capability-gated, zero-reset 32-bit control register with read-only zero reserved bits.
`timescale 1ns/1ps
module psr_masked_reg
#(
    parameter logic [31:0] impl_mask = 32'h0000_0000
)
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [31:0] wdata,
    input wire logic [31:0] cap_mask,
    output logic [31:0] value
);
    import psr_pkg::*;

    typedef struct packed
    {
        logic [31:0] ctrl_q;
    } psr_mreg_state_type;

    psr_mreg_state_type st_q;
    psr_mreg_state_type st_d;
    logic [31:0] wmask;

    always_comb
    begin
        st_d = st_q;
        wmask = impl_mask & cap_mask;
        if (wr_en)
        begin
            st_d.ctrl_q = (st_q.ctrl_q & ~wmask) | (wdata & wmask);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            st_q.ctrl_q <= psr_reset_value;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign value = st_q.ctrl_q;

endmodule : psr_masked_reg

// File: rtl/psr_bus_read.sv
// Read data multiplexer for the reset control registers.
`timescale 1ns/1ps
module psr_bus_read
(
    input wire logic [11:0] addr,
    input wire logic [31:0] periph_val,
    input wire logic [31:0] port_val,
    output logic [31:0] rdata
);
    import psr_pkg::*;

    always_comb
    begin
        // Unmapped offsets read as zero so software sees a defined answer.
        unique case (psr_decode(addr))
            psr_sel_periph: rdata = periph_val;
            psr_sel_port: rdata = port_val;
            default: rdata = 32'h0000_0000;
        endcase
    end

endmodule : psr_bus_read

// File: rtl/psr_top.sv
// Peripheral soft reset control registers with per-peripheral reset outputs.
//
// Function
// - Writes gated per bit by capability masks b and d.
// - Bit 24 of register one resets comparator zero.
// - Bits 18, 17, 16 reset general purpose counters two, one, zero.
// - Bit 12 of register one resets two-wire unit zero.
// - Bit 4 of register one resets synchronous serial unit zero.
// - Bits 1 and 0 reset async serial units one and zero.
// - Register two bits 4 to 0 reset ports E to A.
// - Reserved bits read zero and ignore writes.
// - Both registers are 32 bits and clear to zero on reset.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module psr_top
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [psr_pkg::psr_addr_w-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [31:0] capability_mask_b,
    input wire logic [31:0] capability_mask_d,
    output logic comparator_zero_reset,
    output logic gp_counter_two_reset,
    output logic gp_counter_one_reset,
    output logic gp_counter_zero_reset,
    output logic two_wire_unit_zero_reset,
    output logic sync_serial_zero_reset,
    output logic async_serial_one_reset,
    output logic async_serial_zero_reset,
    output logic port_a_reset,
    output logic port_b_reset,
    output logic port_c_reset,
    output logic port_d_reset,
    output logic port_e_reset
);
    import psr_pkg::*;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [31:0] peripheral_reset_ctrl_1;
    logic [31:0] port_reset_ctrl_2;
    logic [31:0] read_mux;
    psr_sel_type sel;

    assign sel = psr_decode(reg_addr);

    psr_masked_reg
    #(
        .impl_mask(psr_periph_impl)
    )
    u_periph
    (
        .mclk(mclk),
        .rstn(rstn),
        .wr_en(reg_wr && (sel == psr_sel_periph)),
        .wdata(reg_wdata),
        .cap_mask(capability_mask_b),
        .value(peripheral_reset_ctrl_1)
    );

    psr_masked_reg
    #(
        .impl_mask(psr_port_impl)
    )
    u_port
    (
        .mclk(mclk),
        .rstn(rstn),
        .wr_en(reg_wr && (sel == psr_sel_port)),
        .wdata(reg_wdata),
        .cap_mask(capability_mask_d),
        .value(port_reset_ctrl_2)
    );

    psr_bus_read u_read
    (
        .addr(reg_addr),
        .periph_val(peripheral_reset_ctrl_1),
        .port_val(port_reset_ctrl_2),
        .rdata(read_mux)
    );

    // ------------------------------------------------------------
    // Output state
    // ------------------------------------------------------------
    // Outputs are registered copies, so a reset line follows its bit one cycle
    // after the write lands; this keeps every top output straight from a flop.
    typedef struct packed
    {
        logic [31:0] rdata_q;
        logic [7:0] periph_rst_q;
        logic [psr_port_count-1:0] port_rst_q;
    } psr_top_state_type;

    psr_top_state_type st_q;
    psr_top_state_type st_d;

    always_comb
    begin
        st_d = st_q;
        // Read data stands only in the cycle after the read strobe.
        st_d.rdata_q = reg_rd ? read_mux : 32'h0000_0000;
        st_d.periph_rst_q[7] = peripheral_reset_ctrl_1[psr_bit_comparator_zero];
        st_d.periph_rst_q[6] = peripheral_reset_ctrl_1[psr_bit_gp_counter_two];
        st_d.periph_rst_q[5] = peripheral_reset_ctrl_1[psr_bit_gp_counter_one];
        st_d.periph_rst_q[4] = peripheral_reset_ctrl_1[psr_bit_gp_counter_zero];
        st_d.periph_rst_q[3] = peripheral_reset_ctrl_1[psr_bit_two_wire_zero];
        st_d.periph_rst_q[2] = peripheral_reset_ctrl_1[psr_bit_sync_serial_zero];
        st_d.periph_rst_q[1] = peripheral_reset_ctrl_1[psr_bit_async_serial_one];
        st_d.periph_rst_q[0] = peripheral_reset_ctrl_1[psr_bit_async_serial_zero];
        st_d.port_rst_q = port_reset_ctrl_2[psr_port_count-1:0];
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            st_q.rdata_q <= psr_reset_value;
            st_q.periph_rst_q <= 8'h00;
            st_q.port_rst_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata_q;
    assign comparator_zero_reset = st_q.periph_rst_q[7];
    assign gp_counter_two_reset = st_q.periph_rst_q[6];
    assign gp_counter_one_reset = st_q.periph_rst_q[5];
    assign gp_counter_zero_reset = st_q.periph_rst_q[4];
    assign two_wire_unit_zero_reset = st_q.periph_rst_q[3];
    assign sync_serial_zero_reset = st_q.periph_rst_q[2];
    assign async_serial_one_reset = st_q.periph_rst_q[1];
    assign async_serial_zero_reset = st_q.periph_rst_q[0];
    assign port_a_reset = st_q.port_rst_q[0];
    assign port_b_reset = st_q.port_rst_q[1];
    assign port_c_reset = st_q.port_rst_q[2];
    assign port_d_reset = st_q.port_rst_q[3];
    assign port_e_reset = st_q.port_rst_q[4];

endmodule : psr_top

// File: tb/psr_props.sv
// Checker of the register port and reset outputs of the peripheral soft reset block.
`timescale 1ns/1ps
module psr_props
    import psr_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [31:0] capability_mask_b,
    input wire logic [31:0] capability_mask_d,
    input wire logic comparator_zero_reset,
    input wire logic gp_counter_two_reset,
    input wire logic gp_counter_one_reset,
    input wire logic gp_counter_zero_reset,
    input wire logic two_wire_unit_zero_reset,
    input wire logic sync_serial_zero_reset,
    input wire logic async_serial_one_reset,
    input wire logic async_serial_zero_reset,
    input wire logic port_a_reset,
    input wire logic port_b_reset,
    input wire logic port_c_reset,
    input wire logic port_d_reset,
    input wire logic port_e_reset
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // The output lags the register, so a write shows two edges after its strobe.
    a_comp_write: assert property (reg_wr && reg_addr == psr_off_periph &&
        capability_mask_b[24] |-> ##2 comparator_zero_reset == $past(reg_wdata[24], 2))
        else $error("comparator reset missed a write");
    a_mask_hold: assert property (reg_wr && reg_addr == psr_off_port &&
        !capability_mask_d[0] |-> ##2 $stable(port_a_reset)) else $error("masked write took");
    a_port_rsvd: assert property (reg_rd && reg_addr == psr_off_port |=>
        reg_rdata[31:5] == 27'h000_0000) else $error("port reserved bits not zero");
    a_periph_rsvd: assert property (reg_rd && reg_addr == psr_off_periph |=>
        (reg_rdata & ~psr_periph_impl) == 32'h0000_0000) else $error("reserved bits set");
    a_unmapped_zero: assert property (reg_rd && reg_addr != psr_off_periph &&
        reg_addr != psr_off_port |=> reg_rdata == 32'h0000_0000) else $error("unmapped read");
    a_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");
    a_port_mirror: assert property (reg_rd && reg_addr == psr_off_port |=>
        reg_rdata[4:0] == {port_e_reset, port_d_reset, port_c_reset, port_b_reset,
        port_a_reset}) else $error("port outputs differ from register");
    a_timer_mirror: assert property (reg_rd && reg_addr == psr_off_periph |=>
        reg_rdata[18:16] == {gp_counter_two_reset, gp_counter_one_reset,
        gp_counter_zero_reset}) else $error("counter outputs differ from register");
    a_reset_clear: assert property ($rose(rstn) |-> !(comparator_zero_reset ||
        port_e_reset || async_serial_zero_reset)) else $error("output set after reset");
    c_wr_periph: cover property (reg_wr && reg_addr == psr_off_periph);
    c_wr_masked: cover property (reg_wr && capability_mask_d == 32'h0000_0000);
    c_rd_port: cover property (reg_rd && reg_addr == psr_off_port);
endmodule : psr_props

bind psr_top psr_props i_psr_props (.*);

// File: tb/psr_top_test.sv
// Self-checking random testbench of the peripheral soft reset block.
`timescale 1ns/1ps
module psr_top_test;
    import psr_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] capability_mask_b = 32'hffff_ffff;
    logic [31:0] capability_mask_d = 32'hffff_ffff;
    logic comparator_zero_reset, gp_counter_two_reset, gp_counter_one_reset;
    logic gp_counter_zero_reset, two_wire_unit_zero_reset, sync_serial_zero_reset;
    logic async_serial_one_reset, async_serial_zero_reset, port_a_reset, port_b_reset;
    logic port_c_reset, port_d_reset, port_e_reset;
    logic [31:0] exp_1 = 32'h0000_0000;
    logic [31:0] exp_2 = 32'h0000_0000;
    logic [31:0] r;
    logic [15:0] seed = 16'h9a82;
    int fail_count = 0;
    int n_tests = 0;

    psr_top i_psr_top (.*);

    initial forever #25 mclk = ~mclk;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr_step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_step

    task rnd(output logic [31:0] v);
        seed = lfsr_step(seed);
        v[31:16] = seed;
        seed = lfsr_step(seed);
        v[15:0] = seed;
    endtask : rnd

    function automatic logic [31:0] merge(input logic [31:0] o, d, m, impl);
        return (o & ~(m & impl)) | (d & m & impl);
    endfunction : merge

    function automatic logic [11:0] pick(input logic [31:0] v);
        return v[1:0] == 2'd0 ? psr_off_periph : v[1:0] == 2'd1 ? psr_off_port : v[13:2];
    endfunction : pick

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t ns: %s", $time, msg);
        end
    endtask : chk

    // Strobes are set once per call so back to back cycles never double-assign them.
    task bus(input logic w, input logic rd, input logic [11:0] a, input logic [31:0] d);
        reg_wr <= w;
        reg_rd <= rd;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        #1;
        if (w && a == psr_off_periph) exp_1 = merge(exp_1, d, capability_mask_b, psr_periph_impl);
        if (w && a == psr_off_port) exp_2 = merge(exp_2, d, capability_mask_d, psr_port_impl);
        if (rd)
        begin
            chk(reg_rdata, a == psr_off_periph ? exp_1 : a == psr_off_port ? exp_2 :
                32'h0, "read");
            chk({24'h0, comparator_zero_reset, gp_counter_two_reset, gp_counter_one_reset,
                gp_counter_zero_reset, two_wire_unit_zero_reset, sync_serial_zero_reset,
                async_serial_one_reset, async_serial_zero_reset}, {24'h0, exp_1[24],
                exp_1[18:16], exp_1[12], exp_1[4], exp_1[1:0]}, "peripheral outputs");
            chk({27'h0, port_e_reset, port_d_reset, port_c_reset, port_b_reset, port_a_reset},
                {27'h0, exp_2[4:0]}, "port outputs");
        end
    endtask : bus

    task tally_and_finish();
        if (fail_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #(2000 * 50);
        fail_count++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        #1;
        bus(1'b0, 1'b1, psr_off_periph, 32'h0);
        bus(1'b0, 1'b1, psr_off_port, 32'h0);
        bus(1'b1, 1'b0, psr_off_periph, 32'hffff_ffff);
        bus(1'b1, 1'b0, psr_off_port, 32'hffff_ffff);
        bus(1'b0, 1'b1, psr_off_port, 32'h0);
        bus(1'b0, 1'b1, psr_off_periph, 32'h0);
        // Both masks closed: every write before the random loop must leave the registers untouched.
        capability_mask_b <= 32'h0000_0000;
        capability_mask_d <= 32'h0000_0000;
        bus(1'b1, 1'b0, psr_off_periph, 32'h0);
        bus(1'b1, 1'b0, psr_off_port, 32'h0);
        bus(1'b0, 1'b1, psr_off_port, 32'h0);
        bus(1'b1, 1'b0, 12'h040, 32'hffff_ffff);
        bus(1'b0, 1'b1, 12'h040, 32'h0);
        bus(1'b0, 1'b1, psr_off_periph, 32'h0);
        repeat (300)
        begin
            rnd(r);
            capability_mask_b <= r;
            rnd(r);
            capability_mask_d <= r;
            rnd(r);
            bus(1'b1, 1'b0, pick(r), {r[15:0], r[31:16]});
            bus(1'b0, 1'b1, pick(r >> 7), 32'h0);
        end
        rstn <= 1'b0;
        exp_1 = 32'h0000_0000;
        exp_2 = 32'h0000_0000;
        bus(1'b0, 1'b0, psr_off_port, 32'h0);
        rstn <= 1'b1;
        bus(1'b0, 1'b1, psr_off_periph, 32'h0);
        bus(1'b0, 1'b1, psr_off_port, 32'h0);
        bus(1'b0, 1'b0, psr_off_port, 32'h0);
        tally_and_finish();
    end
endmodule : psr_top_test
